// ==== design/kpi_top.sv ====
// Keypad pin interrupt block with AXI4-Lite register slave
//
// The placing of the registers and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/100ps
`include "kpi_defines.svh"

module kpi_top #(
    parameter int PINS = 8                          // Number of key input pins
) (
    input  wire logic            i_clock,           // 250 MHz clock
    input  wire logic            i_rst_b,           // Synchronous reset, active low
    input  wire logic [PINS-1:0] i_key_input_pin,   // Asynchronous key pins
    input  wire logic            i_debug_halt,      // Background debug halt, no effect
    input  wire logic            i_deep_stop_wake,  // Pulse: wake from deep stop
    input  wire logic [11:0]     i_awaddr,          // Write address
    input  wire logic            i_awvalid,         // Write address valid
    output logic                 o_awready,         // Write address ready
    input  wire logic [31:0]     i_wdata,           // Write data
    input  wire logic [3:0]      i_wstrb,           // Write byte strobes
    input  wire logic            i_wvalid,          // Write data valid
    output logic                 o_wready,          // Write data ready
    output logic [1:0]           o_bresp,           // Write response
    output logic                 o_bvalid,          // Write response valid
    input  wire logic            i_bready,          // Write response ready
    input  wire logic [11:0]     i_araddr,          // Read address
    input  wire logic            i_arvalid,         // Read address valid
    output logic                 o_arready,         // Read address ready
    output logic [31:0]          o_rdata,           // Read data
    output logic [1:0]           o_rresp,           // Read response
    output logic                 o_rvalid,          // Read data valid
    input  wire logic            i_rready,          // Read data ready
    output logic                 o_irq,             // Interrupt request / wake
    output logic [PINS-1:0]      o_pull_down_sel    // 1: pull resistor is pull-down
);

    // =========================================================================
    // Register word indices, sized to the decoded address field
    localparam logic [9:0] IDX_STATUS   = 10'(`KPI_OFS_STATUS_CONTROL >> 2);
    localparam logic [9:0] IDX_PIN_EN   = 10'(`KPI_OFS_PIN_ENABLE >> 2);
    localparam logic [9:0] IDX_POLARITY = 10'(`KPI_OFS_POLARITY >> 2);
    localparam logic [9:0] IDX_POWER    = 10'(`KPI_OFS_POWER_MODE >> 2);

    // =========================================================================
    // Pin synchronisers and sample history
    // Asynchronous stop-mode detection is modelled by the same sampled path,
    // since the clock keeps running in this model.
    logic [PINS-1:0] sync1_reg, sync1_next;
    logic [PINS-1:0] sync2_reg, sync2_next;
    logic [PINS-1:0] prev_reg, prev_next;
    logic [PINS-1:0] armed_reg, armed_next;

    // =========================================================================
    // Control and status state
    kpi_pkg::kpi_ctrl_t ctrl_reg, ctrl_next;
    logic               flag_reg, flag_next;
    logic               deep_stop_reg, deep_stop_next;
    logic               irq_reg, irq_next;
    logic [PINS-1:0]    pull_reg, pull_next;

    // =========================================================================
    // Bus slave state
    kpi_pkg::kpi_wstate_t wstate_reg, wstate_next;
    logic                 aw_have_reg, aw_have_next;
    logic                 w_have_reg, w_have_next;
    logic [11:0]          awaddr_reg, awaddr_next;
    logic [31:0]          wdata_reg, wdata_next;
    logic [3:0]           wstrb_reg, wstrb_next;
    logic [1:0]           bresp_reg, bresp_next;
    logic                 arready_reg, arready_next;
    logic                 rvalid_reg, rvalid_next;
    logic [31:0]          rdata_reg, rdata_next;
    logic [1:0]           rresp_reg, rresp_next;
    logic                 awready_reg;
    logic                 wready_reg;

    // Per-pin and combined detection terms, write decode terms and status read value
    logic [PINS-1:0] asserted;
    logic [PINS-1:0] edge_hit;
    logic [PINS-1:0] level_hit;
    logic            any_event;
    logic            any_asserted;
    logic            wr_fire;
    logic            wr_ack;
    logic            wr_lane0;
    logic [7:0]      sc_read;

    // Pin path: two flops, then one history sample for edge compare
    always_comb begin
        sync1_next = i_key_input_pin;
        sync2_next = sync1_reg;
        prev_next  = sync2_reg;                                       // R16
    end

    // Detection terms; asserted level follows polarity bit
    always_comb begin
        asserted     = ~(sync2_reg ^ ctrl_reg.polarity);             // R14
        edge_hit     = asserted & ~(~(prev_reg ^ ctrl_reg.polarity))
                       & armed_reg & ctrl_reg.pin_enable;            // R16 R17 R13
        level_hit    = ctrl_reg.mode_level ? (asserted & ctrl_reg.pin_enable)
                                           : '0;                     // R2 R12
        any_event    = |(edge_hit | level_hit);                      // R1 R3
        any_asserted = |(asserted & ctrl_reg.pin_enable);
        sc_read      = {4'h0, flag_reg, 1'b0, ctrl_reg.irq_enable,
                        ctrl_reg.mode_level};                        // R8 R10
    end

    // Write decode: commit happens once both address and data are held
    always_comb begin
        wr_fire  = (wstate_reg == kpi_pkg::KPI_W_HOLD);
        wr_lane0 = wr_fire && wstrb_reg[0];
        wr_ack   = wr_lane0 && (awaddr_reg[11:2] == IDX_STATUS)
                   && wdata_reg[`KPI_BIT_ACK];                       // R10
    end

    // Control, flag, deep stop and arming next state
    always_comb begin
        ctrl_next      = ctrl_reg;
        flag_next      = flag_reg;
        deep_stop_next = deep_stop_reg;
        armed_next     = armed_reg;
        // A pin arms once seen deasserted; disabled pins drop their arming
        armed_next     = (armed_reg | ~asserted) & ctrl_reg.pin_enable;  // R17
        if (wr_lane0) begin
            unique case (awaddr_reg[11:2])
                IDX_STATUS: begin
                    ctrl_next.irq_enable = wdata_reg[`KPI_BIT_IRQ_EN];   // R11
                    ctrl_next.mode_level = wdata_reg[`KPI_BIT_MODE];     // R12
                end
                IDX_PIN_EN: begin
                    ctrl_next.pin_enable = wdata_reg[7:0];               // R13
                end
                IDX_POLARITY: begin
                    ctrl_next.polarity = wdata_reg[7:0];                 // R14
                end
                IDX_POWER: begin
                    deep_stop_next = wdata_reg[`KPI_BIT_DEEP_STOP];      // R6
                end
                default: begin
                end
            endcase
        end
        // Flag write bit is ignored; acknowledge clears, event wins over it
        if (wr_ack && !(ctrl_reg.mode_level && any_asserted)) begin
            flag_next = 1'b0;                                        // R18 R19
        end
        if (any_event) begin
            flag_next = 1'b1;                                        // R9 R18 R7 R4 R5
        end
        // Deep stop freezes detection; the halt input is deliberately unused
        if (deep_stop_reg) begin
            flag_next  = flag_reg;                                   // R6
            armed_next = '0;
        end
    end

    // Registered outputs toward the processor and the pad
    always_comb begin
        irq_next  = flag_next && ctrl_next.irq_enable;               // R20 R3 R4 R5
        pull_next = ctrl_next.polarity & ctrl_next.pin_enable;       // R15
    end

    // Write channel: accept address and data in either order
    always_comb begin
        wstate_next  = wstate_reg;
        aw_have_next = aw_have_reg;
        w_have_next  = w_have_reg;
        awaddr_next  = awaddr_reg;
        wdata_next   = wdata_reg;
        wstrb_next   = wstrb_reg;
        bresp_next   = bresp_reg;
        unique case (wstate_reg)
            kpi_pkg::KPI_W_IDLE: begin
                // Take each half only on a real handshake, so a request that
                // arrives before ready rises is not captured twice
                if (i_awvalid && awready_reg && !aw_have_reg) begin
                    aw_have_next = 1'b1;
                    awaddr_next  = i_awaddr;
                end
                if (i_wvalid && wready_reg && !w_have_reg) begin
                    w_have_next = 1'b1;
                    wdata_next  = i_wdata;
                    wstrb_next  = i_wstrb;
                end
                if (aw_have_next && w_have_next) begin
                    wstate_next = kpi_pkg::KPI_W_HOLD;
                end
            end
            kpi_pkg::KPI_W_HOLD: begin
                bresp_next   = (awaddr_next[11:4] == 8'h00) ? `KPI_RESP_OKAY
                                                            : `KPI_RESP_SLVERR;
                aw_have_next = 1'b0;
                w_have_next  = 1'b0;
                wstate_next  = kpi_pkg::KPI_W_RESP;
            end
            kpi_pkg::KPI_W_RESP: begin
                if (i_bready) begin
                    wstate_next = kpi_pkg::KPI_W_IDLE;
                end
            end
            default: begin
                wstate_next = kpi_pkg::KPI_W_IDLE;
            end
        endcase
    end

    // Read channel: one read at a time, data ready one cycle after address
    always_comb begin
        arready_next = 1'b0;
        rvalid_next  = rvalid_reg;
        rdata_next   = rdata_reg;
        rresp_next   = rresp_reg;
        if (rvalid_reg && i_rready) begin
            rvalid_next = 1'b0;
        end
        if (!rvalid_reg && !arready_reg && i_arvalid) begin
            arready_next = 1'b1;
            rvalid_next  = 1'b1;
            rresp_next   = `KPI_RESP_OKAY;
            unique case (i_araddr)
                `KPI_OFS_STATUS_CONTROL: rdata_next = {24'h000000, sc_read};   // R8 R9
                `KPI_OFS_PIN_ENABLE:     rdata_next = {24'h000000, ctrl_reg.pin_enable};
                `KPI_OFS_POLARITY:       rdata_next = {24'h000000, ctrl_reg.polarity};
                `KPI_OFS_POWER_MODE:     rdata_next = {31'h00000000, deep_stop_reg};
                default: begin
                    rdata_next = 32'h00000000;
                    rresp_next = `KPI_RESP_SLVERR;
                end
            endcase
        end
    end

    // State registers; wake from deep stop acts as a reset
    always_ff @(posedge i_clock) begin
        sync1_reg <= sync1_next;
        sync2_reg <= sync2_next;
        prev_reg  <= prev_next;
        if (!i_rst_b || i_deep_stop_wake) begin
            ctrl_reg      <= '0;                                     // R21 R6
            flag_reg      <= 1'b0;
            deep_stop_reg <= 1'b0;
            armed_reg     <= '0;
            irq_reg       <= 1'b0;
            pull_reg      <= '0;
        end else begin
            ctrl_reg      <= ctrl_next;
            flag_reg      <= flag_next;
            deep_stop_reg <= deep_stop_next;
            armed_reg     <= armed_next;
            irq_reg       <= irq_next;
            pull_reg      <= pull_next;
        end
    end

    // Bus slave registers
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            wstate_reg  <= kpi_pkg::KPI_W_IDLE;
            aw_have_reg <= 1'b0;
            w_have_reg  <= 1'b0;
            awaddr_reg  <= 12'h000;
            wdata_reg   <= 32'h00000000;
            wstrb_reg   <= 4'h0;
            bresp_reg   <= `KPI_RESP_OKAY;
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h00000000;
            rresp_reg   <= `KPI_RESP_OKAY;
        end else begin
            wstate_reg  <= wstate_next;
            aw_have_reg <= aw_have_next;
            w_have_reg  <= w_have_next;
            awaddr_reg  <= awaddr_next;
            wdata_reg   <= wdata_next;
            wstrb_reg   <= wstrb_next;
            bresp_reg   <= bresp_next;
            arready_reg <= arready_next;
            rvalid_reg  <= rvalid_next;
            rdata_reg   <= rdata_next;
            rresp_reg   <= rresp_next;
        end
    end

    // Ready flags are registers: high in the first idle cycle, cleared on take
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            awready_reg <= 1'b0;
            wready_reg  <= 1'b0;
        end else begin
            awready_reg <= (wstate_next == kpi_pkg::KPI_W_IDLE) && !aw_have_next;
            wready_reg  <= (wstate_next == kpi_pkg::KPI_W_IDLE) && !w_have_next;
        end
    end

    // Outputs straight from flops, except o_bvalid decoded from the write state
    always_comb begin
        o_awready       = awready_reg;
        o_wready        = wready_reg;
        o_bvalid        = (wstate_reg == kpi_pkg::KPI_W_RESP);
        o_bresp         = bresp_reg;
        o_arready       = arready_reg;
        o_rvalid        = rvalid_reg;
        o_rdata         = rdata_reg;
        o_rresp         = rresp_reg;
        o_irq           = irq_reg;
        o_pull_down_sel = pull_reg;
    end

endmodule // kpi_top

// ==== design/kpi_defines.svh ====
// Register offsets, field positions and reset values for the keypad pin interrupt block
`ifndef KPI_DEFINES_SVH
`define KPI_DEFINES_SVH
// Notes on behaviour
// (R1) Eight input pins, each individually enabled as an interrupt source.
// (R2) Each pin triggers on one edge only, or edge plus matching level.
// (R3) All pins share one common interrupt request that software can enable.
// (R4) Detection keeps running in wait mode; enabled pin wakes when irq enabled.
// (R5) In shallow stop, detect asynchronously; enabled pin wakes when irq enabled.
// (R6) Deep stop disables block; waking from it returns all state to reset.
// (R7) Background debug halt does not stop detection or flag setting.
// (R8) Status/control bits 7:4 always read zero.
// (R9) Bit 3 is read-only event flag; writes leave it unchanged.
// (R10) Bit 2 write-one acknowledges the flag; always reads zero.
// (R11) Bit 1 enables the interrupt request.
// (R12) Bit 0 selects edge-only (0) or edge-and-level (1) detection.
// (R13) Pin enable register bit n enables pin n.
// (R14) Polarity bit n: 0 falling/low, 1 rising/high.
// (R15) Polarity bit turns an enabled pin's pull-up into a pull-down.
// (R16) Edges found by comparing successive clock-cycle samples.
// (R17) Pin must be seen deasserted before an edge on it counts.
// (R18) Edge-only mode: valid edge sets flag; acknowledge clears it.
// (R19) Edge-and-level mode: acknowledge clears only when all enabled pins deasserted.
// (R20) Interrupt request is high exactly while flag and enable are both one.
// (R21) After reset all control bits are zero.

// =============================================================================
// Register byte addresses
`define KPI_OFS_STATUS_CONTROL 12'h000
`define KPI_OFS_PIN_ENABLE     12'h004
`define KPI_OFS_POLARITY       12'h008
`define KPI_OFS_POWER_MODE     12'h00c

// =============================================================================
// Status and control field positions
`define KPI_BIT_FLAG      3
`define KPI_BIT_ACK       2
`define KPI_BIT_IRQ_EN    1
`define KPI_BIT_MODE      0

// Power mode control field positions
`define KPI_BIT_DEEP_STOP 0

// =============================================================================
// Reset values and responses
`define KPI_RST_BYTE      8'h00
`define KPI_RESP_OKAY     2'h0
`define KPI_RESP_SLVERR   2'h2
`endif

// ==== design/kpi_pkg.sv ====
// Types shared by the keypad pin interrupt block
package kpi_pkg;
    // Control bits written by software
    typedef struct packed {
        logic       irq_enable;   // Interrupt request enable
        logic       mode_level;   // 1: edge and level detection
        logic [7:0] pin_enable;   // Per-pin enable
        logic [7:0] polarity;     // Per-pin active sense
    } kpi_ctrl_t;

    // Bus slave write states
    typedef enum logic [2:0] {
        KPI_W_IDLE = 3'h1,
        KPI_W_RESP = 3'h2,
        KPI_W_HOLD = 3'h4
    } kpi_wstate_t;
endpackage

// ==== test/kpi_keys.sv ====
// Key switch model standing at the far side of the pins
`timescale 1ns/100ps
module kpi_keys (
    input  wire logic [7:0] i_press,     // 1: key held down
    input  wire logic [7:0] i_pull_down, // 1: pull-down fitted
    output logic      [7:0] o_pin        // Level seen on each pin
);
    // A held key pulls the pin away from its resistor; a released key leaves
    // the resistor level, never the last driven value
    assign o_pin = ~(i_press ^ i_pull_down);
endmodule // kpi_keys

// ==== test/kpi_checker_assertions.sv ====
// Port-level checks for the keypad pin interrupt block
`timescale 1ns/100ps
module kpi_checker #(
    parameter int PINS = 8 // Pin count
) (
    input wire logic            i_clock,          // Clock
    input wire logic            i_rst_b,          // Reset
    input wire logic            i_deep_stop_wake, // Wake
    input wire logic [11:0]     i_awaddr,         // AW
    input wire logic            i_awvalid,        // AW
    input wire logic            o_awready,        // AW
    input wire logic [31:0]     i_wdata,          // W
    input wire logic [3:0]      i_wstrb,          // W
    input wire logic            i_wvalid,         // W
    input wire logic            o_wready,         // W
    input wire logic [1:0]      o_bresp,          // B
    input wire logic            o_bvalid,         // B
    input wire logic [11:0]     i_araddr,         // AR
    input wire logic            o_arready,        // AR
    input wire logic [31:0]     o_rdata,          // R
    input wire logic            o_rvalid,         // R
    input wire logic            o_irq,            // Request
    input wire logic [PINS-1:0] o_pull_down_sel   // Pulls
);
    default clocking @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_b);
    // ==========
    // Helper terms: a write taken whole, a status read answered
    logic wr_go;
    logic rd_st;
    assign wr_go = i_awvalid && o_awready && i_wvalid && o_wready;
    assign rd_st = o_rvalid && o_arready && (i_araddr == 12'h000);
    // ==========
    // Checks
    rst_clear_a: assert property ($rose(i_rst_b) |-> !o_irq && !o_bvalid && o_pull_down_sel == '0)
        else $error("outputs not clear after reset");
    wake_clear_a: assert property (i_deep_stop_wake |-> ##2 (!o_irq && o_pull_down_sel == '0))
        else $error("wake left state set");
    rd_zero_a: assert property (rd_st |-> o_rdata[7:4] == 4'h0 && !o_rdata[2])
        else $error("status read shows unused or ack bits");
    rd_wide_a: assert property (o_rvalid |-> o_rdata[31:8] == 24'h0)
        else $error("read data above byte not zero");
    irq_mask_a: assert property (wr_go && i_awaddr == 12'h000 && i_wstrb[0] && !i_wdata[1]
        |-> ##4 !o_irq) else $error("request not masked");
    irq_set_a: assert property (rd_st && o_rdata[3] && o_rdata[1] |-> ##[0:2] o_irq)
        else $error("request missing with flag and enable");
    wr_resp_a: assert property (wr_go |-> ##2 o_bvalid)
        else $error("write response late");
    bad_addr_a: assert property (wr_go && i_awaddr >= 12'h010 |-> ##2 o_bresp == 2'h2)
        else $error("unmapped write not refused");
    ar_pulse_a: assert property (o_arready |-> o_rvalid ##1 !o_arready)
        else $error("read address ready not a pulse");
    pull_off_a: assert property (wr_go && i_awaddr == 12'h004 && i_wstrb[0]
        && i_wdata[7:0] == 8'h00 |-> ##4 o_pull_down_sel == '0) else $error("pull stays");
    cover property (wr_go);
    cover property (rd_st && o_rdata[3]);
    cover property ($rose(o_irq));
endmodule // kpi_checker

bind kpi_top kpi_checker #(.PINS(PINS)) kpi_checker_i (.*);

// ==== test/kpi_top_bench.sv ====
// Self-checking bench for the keypad pin interrupt block
`timescale 1ns/100ps
module kpi_top_bench;
    // ==========
    // Ports, queues and counters
    logic i_clock = 1'b0, i_rst_b = 1'b0, i_debug_halt = 1'b0, i_deep_stop_wake = 1'b0;
    logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
    logic [11:0] i_awaddr = 12'h000, i_araddr = 12'h000;
    logic [31:0] i_wdata = 32'h0, o_rdata, seed = 32'h7bcb6f2b;
    logic [3:0]  i_wstrb = 4'h1;
    logic [7:0]  i_key_input_pin, o_pull_down_sel, press = 8'h00;
    logic [1:0]  o_bresp, o_rresp, wq[$];
    logic [33:0] rq[$];
    int          n_tests = 0, n_mismatch = 0;
    always #2 i_clock = ~i_clock;
    kpi_top #(.PINS(8)) kpi_top_i (.*);
    kpi_keys kpi_keys_i (.i_press(press), .i_pull_down(o_pull_down_sel), .o_pin(i_key_input_pin));
    // ==========
    // Helpers
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic stuck();
        n_mismatch++;
        $display("bus wait ran out");
        give_verdict();
    endtask
    // Address and data go out together; each is let go when taken
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
        logic b;
        b = 1'b1;
        wq.push_back(r);
        i_awaddr <= a;
        i_wdata <= {24'h0, d};
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_bready <= 1'b1;
        for (int k = 0; k < 64 && b; k++) begin
            @(posedge i_clock);
            if (o_awready) i_awvalid <= 1'b0;
            if (o_wready) i_wvalid <= 1'b0;
            b = !o_bvalid;
            if (!b) i_bready <= 1'b0;
        end
        if (b) stuck();
        // Let an edge pass so the next call never re-drives a signal just let go
        @(posedge i_clock);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
        logic w;
        w = 1'b1;
        rq.push_back({r, 24'h0, d});
        i_araddr <= a;
        i_arvalid <= 1'b1;
        i_rready <= 1'b1;
        for (int k = 0; k < 64 && w; k++) begin
            @(posedge i_clock);
            if (o_arready) i_arvalid <= 1'b0;
            w = !o_rvalid;
            if (!w) i_rready <= 1'b0;
        end
        if (w) stuck();
        @(posedge i_clock);
    endtask
    // Answers are matched with the oldest note as they appear
    always @(posedge i_clock) begin
        if (o_rvalid && i_rready) chk("read", {o_rresp, o_rdata}, rq.pop_front());
        if (o_bvalid && i_bready) chk("bresp", {32'h0, o_bresp}, {32'h0, wq.pop_front()});
    end
    // ==========
    // Main sequence
    initial begin
        logic [7:0] en;
        logic [2:0] j, k;
        logic       m, p;
        repeat (3) @(posedge i_clock);
        i_rst_b <= 1'b1;
        @(posedge i_clock);
        for (int a = 0; a < 16; a += 4) rd(a[11:0], 8'h00, 2'h0);
        wr(12'h004, 8'h00, 2'h0);
        wr(12'h000, 8'hff, 2'h0);
        rd(12'h000, 8'h03, 2'h0);
        wr(12'h010, 8'h00, 2'h2);
        rd(12'h010, 8'h00, 2'h2);
        // Upper byte lanes only: the register must stay as it was
        i_wstrb <= 4'he;
        wr(12'h008, 8'hff, 2'h0);
        i_wstrb <= 4'h1;
        rd(12'h008, 8'h00, 2'h0);
        $display("test reset and register access done");
        // Every mode and polarity pairing, with a random pin set and halt level
        for (int it = 0; it < 4; it++) begin
            m = it[0];
            p = it[1];
            seed = xs(seed);
            j = seed[2:0];
            k = j + 3'd1;
            en = ~(8'h01 << j) & (seed[15:8] | (8'h01 << k));
            i_debug_halt <= seed[16];
            wr(12'h008, {8{p}}, 2'h0);
            wr(12'h004, en, 2'h0);
            repeat (8) @(posedge i_clock);
            wr(12'h000, {7'h03, m}, 2'h0);
            repeat (6) @(posedge i_clock);
            rd(12'h000, {7'h01, m}, 2'h0);
            chk("pull", o_pull_down_sel, {8{p}} & en);
            press <= 8'h01 << j;
            repeat (8) @(posedge i_clock);
            rd(12'h000, {7'h01, m}, 2'h0);
            press <= 8'h01 << k;
            repeat (8) @(posedge i_clock);
            rd(12'h000, {7'h05, m}, 2'h0);
            chk("irq", o_irq, 1'b1);
            wr(12'h000, {7'h03, m}, 2'h0);
            repeat (2) @(posedge i_clock);
            rd(12'h000, m ? {7'h05, m} : {7'h01, m}, 2'h0);
            press <= 8'h00;
            repeat (8) @(posedge i_clock);
            wr(12'h000, {7'h02, m}, 2'h0);
            press <= 8'h01 << k;
            repeat (8) @(posedge i_clock);
            rd(12'h000, {7'h04, m}, 2'h0);
            chk("irq", o_irq, 1'b0);
            press <= 8'h00;
            repeat (8) @(posedge i_clock);
            $display("test mode %0d polarity %0d done", m, p);
        end
        wr(12'h00c, 8'h01, 2'h0);
        rd(12'h00c, 8'h01, 2'h0);
        i_deep_stop_wake <= 1'b1;
        @(posedge i_clock);
        i_deep_stop_wake <= 1'b0;
        repeat (3) @(posedge i_clock);
        for (int a = 0; a < 16; a += 4) rd(a[11:0], 8'h00, 2'h0);
        chk("pull", o_pull_down_sel, 8'h00);
        $display("test deep stop wake done");
        repeat (4) @(posedge i_clock);
        give_verdict();
    end
endmodule // kpi_top_bench
